/* logic/dual_monitor_activation.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_monitor_activation
    import dual_monitor_pkg::*;
#(
    parameter int PA_WIDTH = 36,
    // Value arbitrary
    parameter logic [31:0] HDR_REV_ID = 32'h00000001
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic monitor_call,
    input wire logic treatment_supported,
    input wire logic root_operation,
    input wire logic in_system_mgmt_mode,
    input wire dual_monitor_pkg::qword_t monitor_control_reg,
    input wire logic v86_mode,
    input wire logic compat_mode,
    input wire logic mode_64,
    input wire logic [1:0] current_privilege_level,
    input wire logic treatment_active,
    input wire logic long_mode_supported,
    input wire logic pse_supported,
    input wire logic cs_ptr_valid,
    input wire dual_monitor_pkg::qword_t cs_ptr,
    input wire logic launch_state_clear,
    input wire logic [31:0] exit_ctls,
    input wire logic [31:0] exit_ctls_allowed0,
    input wire logic [31:0] exit_ctls_allowed1,
    input wire logic [31:0] store_count,
    input wire dual_monitor_pkg::qword_t store_addr,
    input wire dual_monitor_pkg::qword_t cr0_in,
    input wire dual_monitor_pkg::qword_t cr3_in,
    input wire dual_monitor_pkg::qword_t cr4_in,
    input wire dual_monitor_pkg::qword_t efer_in,
    input wire dual_monitor_pkg::qword_t interrupt_table_reg_base_in,
    output var logic mem_rd_req,
    output var logic [31:0] mem_rd_addr,
    input wire logic mem_rd_ack,
    input wire logic [31:0] mem_rd_data,
    output logic act_done_q,
    output logic act_fail_q,
    output logic call_ignored_q,
    output dual_monitor_pkg::qword_t transfer_ptr_q,
    output dual_monitor_pkg::qword_t cr0_q,
    output dual_monitor_pkg::qword_t cr3_q,
    output dual_monitor_pkg::qword_t cr4_q,
    output dual_monitor_pkg::qword_t dr7_q,
    output dual_monitor_pkg::qword_t debugctl_q,
    output dual_monitor_pkg::qword_t efer_q,
    output logic [15:0] cs_sel_q,
    output logic [15:0] data_sel_q,
    output dual_monitor_pkg::qword_t seg_base_q,
    output logic [31:0] seg_limit_q,
    output dual_monitor_pkg::seg_ar_t cs_ar_q,
    output dual_monitor_pkg::seg_ar_t data_ar_q,
    output logic [15:0] local_table_reg_sel_q,
    output logic local_table_reg_unusable_q,
    output dual_monitor_pkg::qword_t global_table_reg_base_q,
    output logic [15:0] global_table_reg_limit_q,
    output dual_monitor_pkg::qword_t interrupt_table_reg_base_q,
    output logic [15:0] interrupt_table_reg_limit_q,
    output dual_monitor_pkg::qword_t rip_q,
    output dual_monitor_pkg::qword_t rsp_q,
    output dual_monitor_pkg::qword_t flags_register_q,
    output logic cpu_active_q,
    output logic block_nmi_q,
    output logic block_smi_q,
    output logic block_shadow_q,
    output logic pend_dbg_q,
    output logic tlb_flush_q,
    output logic [7:0] phys_addr_width_q
);
    import dual_monitor_pkg::*;

    if (PA_WIDTH < LEGACY_PA_WIDTH || PA_WIDTH > 64)
    begin : g_bad_width
        $error("PA_WIDTH must lie in 32..64");
    end

    function automatic logic beyond_width(input logic [71:0] a, input int w);
        beyond_width = (a >> w) != 72'h0;
    endfunction

    function automatic qword_t monitor_segment_plus(input logic [31:0] base, input logic [31:0] off);
        logic [31:0] s;
        s = base + off;
        monitor_segment_plus = {32'h00000000, s};
    endfunction

    hdr_rd_if hdr ();

    act_state_t state_q;
    logic req_q;
    logic [2:0] idx_q;
    logic feat_lm_q;
    logic [15:0] gdt_lim_q;
    logic [15:0] csel_q;
    logic [31:0] gdt_off_q;
    logic [31:0] ip_off_q;
    logic [31:0] sp_off_q;
    logic [31:0] pt_off_q;
    logic [31:0] monitor_segment_base;
    logic eligible;
    logic cs_ok;
    logic [71:0] store_last;
    int pa_w;
    logic rev_bad;
    logic feat_bad;

    assign hdr.req = req_q;
    assign hdr.idx = idx_q;
    assign monitor_segment_base = monitor_control_reg[31:0] & MCR_BASE_MASK;

    header_word_reader u_reader (
        .clk(clk),
        .rst(rst),
        .monitor_segment_base(monitor_segment_base),
        .hdr(hdr),
        .mem_rd_req(mem_rd_req),
        .mem_rd_addr(mem_rd_addr),
        .mem_rd_ack(mem_rd_ack),
        .mem_rd_data(mem_rd_data)
    );

    always_comb
    begin
        eligible = treatment_supported && root_operation && !in_system_mgmt_mode
            && monitor_control_reg[MCR_VALID] && !v86_mode && !compat_mode
            && current_privilege_level == PRIV_TOP && !treatment_active;
        pa_w = long_mode_supported ? PA_WIDTH : LEGACY_PA_WIDTH;
        store_last = {8'h00, store_addr}
            + ({40'h0000000000, store_count} << STORE_ENTRY_SHIFT) - 72'h1;
        // Checks chained in order; a later one only matters once earlier pass
        cs_ok = cs_ptr_valid && launch_state_clear;
        cs_ok = cs_ok && (exit_ctls & ~exit_ctls_allowed1) == 32'h00000000
            && (exit_ctls_allowed0 & ~exit_ctls) == 32'h00000000;
        if (store_count != 32'h00000000)
        begin
            cs_ok = cs_ok && store_addr[STORE_ALIGN_BITS-1:0] == '0
                && !beyond_width({8'h00, store_addr}, pa_w);
            cs_ok = cs_ok && !beyond_width(store_last, pa_w);
        end
        rev_bad = hdr.data != HDR_REV_ID;
        feat_bad = hdr.data[31:1] != 31'h0 || (hdr.data[0] && !long_mode_supported)
            || (mode_64 && !hdr.data[0]);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            req_q <= 1'b0;
            idx_q <= HW_REV;
            act_done_q <= 1'b0;
            act_fail_q <= 1'b0;
            call_ignored_q <= 1'b0;
        end
        else
        begin
            req_q <= 1'b0;
            act_done_q <= 1'b0;
            act_fail_q <= 1'b0;
            call_ignored_q <= 1'b0;
            unique case (state_q)
                ST_IDLE:
                begin
                    if (monitor_call && !eligible)
                    begin
                        call_ignored_q <= 1'b1;
                    end
                    else if (monitor_call && !cs_ok)
                    begin
                        act_fail_q <= 1'b1;
                    end
                    else if (monitor_call)
                    begin
                        state_q <= ST_WAIT;
                        req_q <= 1'b1;
                        idx_q <= HW_REV;
                    end
                end
                ST_WAIT:
                begin
                    if (hdr.ack)
                    begin
                        if ((idx_q == HW_REV && rev_bad) || (idx_q == HW_FEAT && feat_bad))
                        begin
                            act_fail_q <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                        else if (idx_q == HW_PT_OFF)
                        begin
                            state_q <= ST_LOAD;
                        end
                        else
                        begin
                            req_q <= 1'b1;
                            idx_q <= idx_q + 3'h1;
                        end
                    end
                end
                ST_LOAD:
                begin
                    act_done_q <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Header fields captured as each word after the revision word arrives
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            feat_lm_q <= 1'b0;
            gdt_lim_q <= 16'h0000;
            csel_q <= 16'h0000;
            gdt_off_q <= 32'h00000000;
            ip_off_q <= 32'h00000000;
            sp_off_q <= 32'h00000000;
            pt_off_q <= 32'h00000000;
        end
        else if (state_q == ST_WAIT && hdr.ack)
        begin
            unique case (idx_q)
                HW_FEAT: feat_lm_q <= hdr.data[0];
                HW_GDT_LIM: gdt_lim_q <= hdr.data[15:0];
                HW_GDT_OFF: gdt_off_q <= hdr.data;
                HW_CSEL: csel_q <= hdr.data[15:0];
                HW_IP_OFF: ip_off_q <= hdr.data;
                HW_SP_OFF: sp_off_q <= hdr.data;
                HW_PT_OFF: pt_off_q <= hdr.data;
                HW_REV: feat_lm_q <= feat_lm_q;
            endcase
        end
    end

    logic [15:0] cs_sel_d;
    logic [15:0] data_sel_d;
    qword_t cr3_d;
    qword_t cr4_d;
    qword_t efer_d;

    always_comb
    begin
        cs_sel_d = {csel_q[15:3], 3'b000};
        if (cs_sel_d == SEL_NULL)
        begin
            cs_sel_d = SEL_STEP;
        end
        data_sel_d = cs_sel_d + SEL_STEP;
        if (data_sel_d == SEL_NULL)
        begin
            data_sel_d = SEL_STEP;
        end
        cr3_d = monitor_segment_plus(monitor_segment_base, pt_off_q);
        cr3_d = {32'h00000000, cr3_d[31:12], 7'h00, pt_off_q[4:3], 3'b000};
        cr4_d = cr4_in;
        cr4_d[CR4_MCE] = 1'b0;
        cr4_d[CR4_PGE] = 1'b0;
        cr4_d[CR4_PAE] = feat_lm_q;
        cr4_d[CR4_PSE] = !feat_lm_q && pse_supported;
        efer_d = efer_in;
        if (long_mode_supported)
        begin
            efer_d[EFER_LME] = feat_lm_q;
            efer_d[EFER_LMA] = feat_lm_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            transfer_ptr_q <= '0;
            cr0_q <= '0;
            cr3_q <= '0;
            cr4_q <= '0;
            dr7_q <= '0;
            debugctl_q <= '0;
            efer_q <= '0;
            cs_sel_q <= SEL_NULL;
            data_sel_q <= SEL_NULL;
            seg_base_q <= '0;
            seg_limit_q <= '0;
            cs_ar_q <= '0;
            data_ar_q <= '0;
            local_table_reg_sel_q <= SEL_NULL;
            local_table_reg_unusable_q <= 1'b0;
            global_table_reg_base_q <= '0;
            global_table_reg_limit_q <= 16'h0000;
            interrupt_table_reg_base_q <= '0;
            interrupt_table_reg_limit_q <= 16'h0000;
            rip_q <= '0;
            rsp_q <= '0;
            flags_register_q <= '0;
            cpu_active_q <= 1'b0;
            block_nmi_q <= 1'b0;
            block_smi_q <= 1'b0;
            block_shadow_q <= 1'b0;
            pend_dbg_q <= 1'b0;
            tlb_flush_q <= 1'b0;
            phys_addr_width_q <= 8'h00;
        end
        else
        begin
            phys_addr_width_q <= 8'(pa_w);
            tlb_flush_q <= 1'b0;
            if (state_q == ST_LOAD)
            begin
                transfer_ptr_q <= cs_ptr;
                cr0_q <= (cr0_in & CR0_KEEP) | CR0_SET;
                cr3_q <= cr3_d;
                cr4_q <= cr4_d;
                dr7_q <= DR7_EXIT;
                debugctl_q <= DEBUGCTL_EXIT;
                efer_q <= efer_d;
                cs_sel_q <= cs_sel_d;
                data_sel_q <= data_sel_d;
                seg_base_q <= '0;
                seg_limit_q <= SEG_LIMIT;
                cs_ar_q <= '0;
                cs_ar_q[3:0] <= TYPE_CODE;
                cs_ar_q[AR_S] <= 1'b1;
                cs_ar_q[AR_P] <= 1'b1;
                cs_ar_q[AR_L] <= feat_lm_q && long_mode_supported;
                cs_ar_q[AR_DB] <= !feat_lm_q;
                cs_ar_q[AR_G] <= 1'b1;
                data_ar_q <= '0;
                data_ar_q[3:0] <= TYPE_DATA;
                data_ar_q[AR_S] <= 1'b1;
                data_ar_q[AR_P] <= 1'b1;
                data_ar_q[AR_DB] <= 1'b1;
                data_ar_q[AR_G] <= 1'b1;
                local_table_reg_sel_q <= SEL_NULL;
                local_table_reg_unusable_q <= 1'b1;
                global_table_reg_base_q <= monitor_segment_plus(monitor_segment_base, gdt_off_q);
                global_table_reg_limit_q <= gdt_lim_q;
                interrupt_table_reg_base_q <= interrupt_table_reg_base_in;
                interrupt_table_reg_limit_q <= 16'h0000;
                rip_q <= monitor_segment_plus(monitor_segment_base, ip_off_q);
                rsp_q <= monitor_segment_plus(monitor_segment_base, sp_off_q);
                flags_register_q <= FLAGS_EXIT;
                cpu_active_q <= 1'b1;
                block_nmi_q <= 1'b1;
                block_smi_q <= 1'b1;
                block_shadow_q <= 1'b0;
                pend_dbg_q <= 1'b0;
                // Conservative: flush even where other bits make the change harmless
                tlb_flush_q <= cr3_d[63:CR3_CMP_LO] != cr3_in[63:CR3_CMP_LO]
                    || cr4_d[CR4_PAE] != cr4_in[CR4_PAE]
                    || cr4_d[CR4_PSE] != cr4_in[CR4_PSE]
                    || efer_d[EFER_LMA] != efer_in[EFER_LMA];
            end
        end
    end

    a_ignore_ineligible: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_IDLE && monitor_call && !eligible |=> call_ignored_q && !act_fail_q)
        else $error("ineligible call not ignored");
    a_no_ptr_fails: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_IDLE && monitor_call && eligible && !cs_ptr_valid
        |=> act_fail_q && !req_q)
        else $error("missing structure pointer did not fail");
    a_store_align: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_IDLE && monitor_call && eligible && store_count != 32'h0
        && store_addr[3:0] != 4'h0 |=> act_fail_q)
        else $error("misaligned store area accepted");
    a_fail_skips_fetch: assert property (@(posedge clk) disable iff (rst)
        act_fail_q |-> state_q == ST_IDLE && !req_q ##1 !mem_rd_req)
        else $error("header fetched after failure");
    a_rev_mismatch: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_WAIT && hdr.ack && idx_q == HW_REV && hdr.data != HDR_REV_ID
        |=> act_fail_q && state_q == ST_IDLE)
        else $error("revision mismatch not failed");
    a_feat_reserved: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_WAIT && hdr.ack && idx_q == HW_FEAT && hdr.data[31:1] != 31'h0
        |=> act_fail_q)
        else $error("reserved feature bits accepted");
    a_transfer_ptr: assert property (@(posedge clk) disable iff (rst)
        state_q == ST_LOAD |=> act_done_q && transfer_ptr_q == $past(cs_ptr))
        else $error("transfer pointer not loaded");
    a_cr0_value: assert property (@(posedge clk) disable iff (rst)
        act_done_q |-> (cr0_q & ~CR0_KEEP) == CR0_SET)
        else $error("control zero value wrong");
    a_sel_pair: assert property (@(posedge clk) disable iff (rst)
        act_done_q |-> cs_sel_q[2:0] == 3'b000 && cs_sel_q != SEL_NULL
        && data_sel_q == (cs_sel_q == SEL_WRAP ? SEL_STEP : cs_sel_q + SEL_STEP))
        else $error("selector pairing wrong");
    a_flags_exit: assert property (@(posedge clk) disable iff (rst)
        act_done_q |-> flags_register_q == FLAGS_EXIT && block_smi_q && block_nmi_q)
        else $error("flags or blocking wrong after load");

    c_activation: cover property (@(posedge clk) disable iff (rst) act_done_q);
    c_struct_fail: cover property (@(posedge clk) disable iff (rst)
        state_q == ST_IDLE && act_fail_q);
    c_ignored: cover property (@(posedge clk) disable iff (rst) call_ignored_q);
    c_flush: cover property (@(posedge clk) disable iff (rst) tlb_flush_q);
endmodule
`default_nettype wire

/* logic/dual_monitor_pkg.sv */
`default_nettype none
package dual_monitor_pkg;
    typedef logic [63:0] qword_t;
    typedef logic [16:0] seg_ar_t;

    // Header word indices, four bytes each
    localparam logic [2:0] HW_REV = 3'h0;
    localparam logic [2:0] HW_FEAT = 3'h1;
    localparam logic [2:0] HW_GDT_LIM = 3'h2;
    localparam logic [2:0] HW_GDT_OFF = 3'h3;
    localparam logic [2:0] HW_CSEL = 3'h4;
    localparam logic [2:0] HW_IP_OFF = 3'h5;
    localparam logic [2:0] HW_SP_OFF = 3'h6;
    localparam logic [2:0] HW_PT_OFF = 3'h7;
    localparam int WORD_SHIFT = 2;

    localparam int MCR_VALID = 0;
    localparam logic [31:0] MCR_BASE_MASK = 32'hFFFFF000;

    localparam qword_t CR0_SET = 64'h0000000080000033;
    localparam qword_t CR0_KEEP = 64'h0000000060000000;
    localparam int CR4_PSE = 4;
    localparam int CR4_PAE = 5;
    localparam int CR4_MCE = 6;
    localparam int CR4_PGE = 7;
    localparam int EFER_LME = 8;
    localparam int EFER_LMA = 10;
    localparam int CR3_CMP_LO = 5;

    localparam qword_t DR7_EXIT = 64'h0000000000000400;
    localparam qword_t DEBUGCTL_EXIT = 64'h0000000000000000;
    localparam qword_t FLAGS_EXIT = 64'h0000000000000002;

    localparam logic [15:0] SEL_NULL = 16'h0000;
    localparam logic [15:0] SEL_STEP = 16'h0008;
    localparam logic [15:0] SEL_WRAP = 16'hFFF8;
    localparam logic [31:0] SEG_LIMIT = 32'h0FFFFFFF;
    localparam logic [3:0] TYPE_CODE = 4'hB;
    localparam logic [3:0] TYPE_DATA = 4'h3;
    localparam int AR_S = 4;
    localparam int AR_P = 7;
    localparam int AR_L = 13;
    localparam int AR_DB = 14;
    localparam int AR_G = 15;
    localparam int AR_UNUSABLE = 16;

    localparam int STORE_ALIGN_BITS = 4;
    localparam int STORE_ENTRY_SHIFT = 4;
    localparam int LEGACY_PA_WIDTH = 32;
    localparam logic [1:0] PRIV_TOP = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_LOAD = 2'b10
    } act_state_t;
endpackage
`default_nettype wire

/* logic/hdr_rd_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface hdr_rd_if;
    logic req;
    logic [2:0] idx;
    logic ack;
    logic [31:0] data;
    modport requester (output req, output idx, input ack, input data);
    modport reader (input req, input idx, output ack, output data);
endinterface
`default_nettype wire

/* logic/header_word_reader.sv */
`timescale 1ns/1ps
`default_nettype none
module header_word_reader
    import dual_monitor_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] monitor_segment_base,
    hdr_rd_if.reader hdr,
    output var logic mem_rd_req,
    output var logic [31:0] mem_rd_addr,
    input wire logic mem_rd_ack,
    input wire logic [31:0] mem_rd_data
);
    import dual_monitor_pkg::*;

    // Request stays up until memory answers; address frozen meanwhile
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mem_rd_req <= 1'b0;
            mem_rd_addr <= 32'h00000000;
        end
        else if (hdr.req && !mem_rd_req)
        begin
            mem_rd_req <= 1'b1;
            mem_rd_addr <= monitor_segment_base + (32'(hdr.idx) << WORD_SHIFT);
        end
        else if (mem_rd_ack)
        begin
            mem_rd_req <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hdr.ack <= 1'b0;
            hdr.data <= 32'h00000000;
        end
        else
        begin
            hdr.ack <= mem_rd_req && mem_rd_ack;
            if (mem_rd_req && mem_rd_ack)
            begin
                hdr.data <= mem_rd_data;
            end
        end
    end

    a_rd_addr_hold: assert property (@(posedge clk) disable iff (rst)
        mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr))
        else $error("header read request dropped or address moved");
endmodule
`default_nettype wire

/* testbench/dual_monitor_activation_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_monitor_activation_test;
    import dual_monitor_pkg::*;
    logic clk, rst, monitor_call, treatment_supported, root_operation, in_system_mgmt_mode;
    logic v86_mode, compat_mode, mode_64, treatment_active, long_mode_supported, pse_supported;
    logic cs_ptr_valid, launch_state_clear, mem_rd_req, mem_rd_ack, tlb_flush_q;
    logic act_done_q, act_fail_q, call_ignored_q, local_table_reg_unusable_q, cpu_active_q, block_nmi_q;
    logic block_smi_q, block_shadow_q, pend_dbg_q;
    logic [1:0] current_privilege_level;
    logic [7:0] phys_addr_width_q;
    logic [15:0] cs_sel_q, data_sel_q, local_table_reg_sel_q, global_table_reg_limit_q, interrupt_table_reg_limit_q;
    logic [31:0] exit_ctls, exit_ctls_allowed0, exit_ctls_allowed1, store_count, mem_rd_addr;
    logic [31:0] mem_rd_data, seg_limit_q;
    qword_t monitor_control_reg, cs_ptr, store_addr, cr0_in, cr3_in, cr4_in, efer_in;
    qword_t interrupt_table_reg_base_in, transfer_ptr_q, cr0_q, cr3_q, cr4_q, dr7_q, debugctl_q, efer_q;
    qword_t seg_base_q, global_table_reg_base_q, interrupt_table_reg_base_q, rip_q, rsp_q, flags_register_q;
    seg_ar_t cs_ar_q, data_ar_q;
    logic [31:0] hdr [8];
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    dual_monitor_activation u_dual_monitor_activation (.*);

    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic chk(input qword_t got, input qword_t exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Eligible call, legal structure, store area ending exactly at 4 GB
    task automatic dflt();
        {treatment_supported, root_operation, in_system_mgmt_mode, v86_mode} = 4'hC;
        {compat_mode, mode_64, treatment_active, long_mode_supported} = 4'h0;
        {pse_supported, cs_ptr_valid, launch_state_clear, monitor_call, mem_rd_ack} = 5'h1C;
        current_privilege_level = 2'h0;
        monitor_control_reg = 64'h00100001;
        cs_ptr = 64'hABCD0000;
        {exit_ctls, exit_ctls_allowed0, exit_ctls_allowed1} = {64'h0, 32'hFFFFFFFF};
        store_count = 32'h1;
        store_addr = 64'hFFFFFFF0;
        {cr0_in, cr3_in, cr4_in, efer_in} = {4{64'hFFFFFFFFFFFFFFFF}};
        interrupt_table_reg_base_in = 64'h5000;
        mem_rd_data = 32'h0;
        hdr = '{32'h1, 32'h0, 32'h12340027, 32'h100, 32'hFFFF, 32'h200, 32'h300, 32'h2FFF};
    endtask

    // Outcome is {done, fail, ignored}; header reads answered from hdr
    task automatic run(input logic [2:0] exp);
        int k;
        int n = 0;
        logic [31:0] base;
        base = monitor_control_reg[31:0] & 32'hFFFFF000;
        @(negedge clk);
        monitor_call = 1'h1;
        @(negedge clk);
        monitor_call = 1'h0;
        for (k = 0; k < 60 && {act_done_q, act_fail_q, call_ignored_q} === 3'h0; k++)
        begin
            @(negedge clk);
            // A fresh request: word n of the header, four bytes apart
            if (mem_rd_req === 1'b1 && mem_rd_ack === 1'b0)
            begin
                chk(mem_rd_addr, base + 32'(n * 4));
                n++;
            end
            mem_rd_ack = mem_rd_req;
            mem_rd_data = hdr[mem_rd_addr[4:2]];
        end
        chk({act_done_q, act_fail_q, call_ignored_q}, exp);
    endtask

    initial
    begin
        rst = 1'h1;
        dflt();
        repeat (10) @(negedge clk);
        rst = 1'h0;
        @(negedge clk);
        chk(phys_addr_width_q, 64'h20);
        for (int i = 0; i < 17; i++)
        begin
            dflt();
            case (i)
                0: current_privilege_level = 2'h1;
                1: treatment_active = 1'h1;
                2: treatment_supported = 1'h0;
                3: root_operation = 1'h0;
                4: in_system_mgmt_mode = 1'h1;
                5: monitor_control_reg[0] = 1'h0;
                6: v86_mode = 1'h1;
                7: compat_mode = 1'h1;
                8: cs_ptr_valid = 1'h0;
                9: launch_state_clear = 1'h0;
                10: exit_ctls_allowed0 = 32'h1;
                11: store_addr = 64'h8;
                12: store_count = 32'h2;
                13: hdr[0] = 32'h2;
                14: hdr[1] = 32'h2;
                15: hdr[1] = 32'h1;
                default: mode_64 = 1'h1;
            endcase
            run(i < 8 ? 3'h1 : 3'h2);
            $display("refusal case %0d done", i);
        end
        dflt();
        run(3'h4);
        chk(transfer_ptr_q, 64'hABCD0000);
        chk(cr0_q, 64'hE0000033);
        chk(cr3_q, 64'h102018);
        chk(cr4_q, 64'hFFFFFFFFFFFFFF1F);
        chk(dr7_q, 64'h400);
        chk(debugctl_q, 64'h0);
        chk({cs_sel_q, data_sel_q, local_table_reg_sel_q, global_table_reg_limit_q}, 64'hFFF8000800000027);
        chk({seg_base_q[31:0], seg_limit_q}, 64'h0FFFFFFF);
        chk({cs_ar_q, data_ar_q}, {17'h0C09B, 17'h0C093});
        chk({local_table_reg_unusable_q, interrupt_table_reg_limit_q}, 64'h10000);
        chk(global_table_reg_base_q + interrupt_table_reg_base_q, 64'h105100);
        chk({rip_q[31:0], rsp_q[31:0]}, 64'h0010020000100300);
        chk(flags_register_q, 64'h2);
        chk({cpu_active_q, block_nmi_q, block_smi_q, block_shadow_q, pend_dbg_q}, 64'h1C);
        chk(tlb_flush_q, 64'h1);
        chk(efer_q, 64'hFFFFFFFFFFFFFFFF);
        $display("activation case done");
        dflt();
        {long_mode_supported, mode_64, efer_in} = {2'h3, 64'h0};
        hdr[1] = 32'h1;
        run(3'h4);
        chk(phys_addr_width_q, 64'h24);
        chk(cr4_q, 64'hFFFFFFFFFFFFFF2F);
        chk(efer_q, 64'h500);
        chk(cs_ar_q, 17'h0A09B);
        chk(tlb_flush_q, 64'h1);
        $display("long mode case done");
        dflt();
        hdr[4] = 32'h7;
        run(3'h4);
        chk({cs_sel_q, data_sel_q}, 64'h00080010);
        $display("null selector case done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
